// ==== core/srsp_pkg.sv ====
// Constants for the serial register slave port
// Function
// - Chip select high selects two-wire mode
// - Format bit chooses four-wire or three-wire pins
// - Clock polarity 1 and phase 1
// - Four-wire: receive on input, send on output
// - Data captured on serial clock rising edge
// - Pointer advances after each data byte while the multi-byte flag is set
// - Pointer keeps advancing until chip select rises
// - Output data changes after falling clock edge
package srsp_pkg;
    localparam int          ADDR_W         = 6;
    localparam int          DATA_W         = 8;
    localparam int          REG_COUNT      = 64;
    localparam logic [5:0]  FMT_OFFSET     = 6'h31;
    localparam logic [7:0]  FMT_RESET      = 8'h00;
    localparam logic [7:0]  REG_RESET      = 8'h00;
    localparam int          FMT_WIRE_BIT   = 6;
    localparam int          HDR_RW_BIT     = 7;
    localparam int          HDR_MB_BIT     = 6;
    localparam logic [2:0]  LAST_BIT       = 3'h7;
    // Timing of the serial clock against the 200 MHz core clock
    localparam int          CLK_PERIOD_PS  = 5000;
    localparam int          SCLK_MAX_KHZ   = 5000;
    localparam int          SCLK_PERIOD_PS = 1000000000 / SCLK_MAX_KHZ;
    localparam int          SCLK_LOW_PS    = SCLK_PERIOD_PS * 4 / 10;
    localparam int          SCLK_LOW_CYC   = SCLK_LOW_PS / CLK_PERIOD_PS;
    localparam int          MIN_PHASE_CYC  = 4;
endpackage

// ==== core/srsp_sync.sv ====
// Multi-stage synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module srsp_sync #(
    parameter int          WIDTH  = 1,
    parameter int          STAGES = 2,
    parameter logic [0:0]  INIT   = 1'b0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [STAGES-1:0][WIDTH-1:0] stage;

    // Refuse chains too short to settle metastability
    if (STAGES < 2) begin : g_bad
        $error("srsp_sync needs at least two stages");
    end

    // Shift chain; only the last stage is visible
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= {STAGES{{WIDTH{INIT}}}};
        end else if (ce) begin
            stage <= {stage[STAGES-2:0], d};
        end
    end

    assign q = stage[STAGES-1];
endmodule
`default_nettype wire

// ==== core/srsp_port.sv ====
// Serial register slave port: SPI mode 3 slave over a 64-byte register file
`timescale 1ns/1ps
`default_nettype none
module srsp_port (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        sdio_in,
    output logic             sdio_out,
    output logic             sdio_oe,
    output logic             sdo_out,
    output logic             sdo_oe,
    output logic             two_wire_mode,
    output logic       [7:0] output_format_control,
    output logic             reg_wr_strobe,
    output logic       [5:0] reg_wr_addr,
    output logic       [7:0] reg_wr_data
);
    // Behaviour in short:
    // Chip select high parks the port and flags two-wire mode.
    // Chip select low runs a mode 3 slave frame.
    // First byte: direction, multi-byte flag, address.
    // Later bytes: data, MSB first, one per eight clocks.
    // Bits are taken on the synced serial clock rise.
    // Read bits move on the synced serial clock fall.
    // Format bit picks shared pin or separate output pin.
    // Pointer steps per data byte only with the flag set.
    // Pointer wraps from the top register to the bottom.
    // A partial byte at chip select rise is dropped.
    // Hazard: pins are sampled, so the core clock
    // must see each serial clock phase for four cycles.

    // Whole port state in one register
    typedef struct packed {
        // Edge detection and frame progress
        logic                                         sclk_q;
        logic                                         in_hdr;
        logic                                         first_done;
        // Header fields of the running frame
        logic                                         rw;
        logic                                         multi_byte_flag;
        logic                                         drive;
        // Bit counter, pointer and shifters
        logic [2:0]                                   bit_cnt;
        logic [srsp_pkg::ADDR_W-1:0]                  addr;
        logic [srsp_pkg::DATA_W-1:0]                  rx;
        logic [srsp_pkg::DATA_W-1:0]                  tx;
        // Pin drivers and register side outputs
        logic                                         out_bit;
        logic                                         sdio_oe;
        logic                                         sdo_oe;
        logic                                         two_wire;
        logic                                         wr_strobe;
        logic [srsp_pkg::ADDR_W-1:0]                  wr_addr;
        logic [srsp_pkg::DATA_W-1:0]                  wr_data;
        logic [srsp_pkg::REG_COUNT-1:0][srsp_pkg::DATA_W-1:0] regs;
    } srsp_state_t;

    srsp_state_t s;
    srsp_state_t next_s;
    logic        rst_n;
    logic [2:0]  pins_s;
    logic        cs_s;
    logic        sclk_s;
    logic        sdi_s;

    // The core clock must see every serial clock phase
    if (srsp_pkg::SCLK_LOW_CYC < srsp_pkg::MIN_PHASE_CYC) begin : g_bad
        $error("core clock too slow for the serial clock");
    end

    // Register file must fill the whole address space
    if (srsp_pkg::REG_COUNT != (1 << srsp_pkg::ADDR_W)) begin : g_bad_depth
        $error("register count must match the address width");
    end

    // Header layout: direction above flag above address
    if (srsp_pkg::HDR_MB_BIT != srsp_pkg::ADDR_W) begin : g_bad_flag
        $error("multi-byte flag must sit just above the address");
    end
    if (srsp_pkg::HDR_RW_BIT != srsp_pkg::DATA_W - 1) begin : g_bad_dir
        $error("direction bit must be the first bit sent");
    end

    // Wire select must lie inside the format register
    if (srsp_pkg::FMT_WIRE_BIT >= srsp_pkg::DATA_W) begin : g_bad_fmt
        $error("wire select bit outside the format register");
    end

    // Reset release through two flip-flops
    srsp_sync #(
        .WIDTH  (1),
        .STAGES (2),
        .INIT   (1'b0)
    ) u_rst_sync (
        .clk   (clk),
        .rst_n (resetn),
        .ce    (1'b1),
        .d     (1'b1),
        .q     (rst_n)
    );

    // Pins from the master cross into the core clock
    srsp_sync #(
        .WIDTH  (3),
        .STAGES (2),
        .INIT   (1'b1)
    ) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     ({cs_n, sclk, sdio_in}),
        .q     (pins_s)
    );

    assign cs_s   = pins_s[2];
    assign sclk_s = pins_s[1];
    assign sdi_s  = pins_s[0];

    // Next-state logic of the whole port
    always_comb begin
        logic                         rise;
        logic                         fall;
        logic                         three_wire;
        logic [srsp_pkg::DATA_W-1:0]  rx_next;
        logic [srsp_pkg::ADDR_W-1:0]  addr_inc;
        rise       = 1'b0;
        fall       = 1'b0;
        three_wire = 1'b0;
        rx_next    = '0;
        addr_inc   = '0;
        next_s     = s;

        rise       = sclk_s & ~s.sclk_q;
        fall       = ~sclk_s & s.sclk_q;
        three_wire = s.regs[srsp_pkg::FMT_OFFSET][srsp_pkg::FMT_WIRE_BIT];
        rx_next    = {s.rx[srsp_pkg::DATA_W-2:0], sdi_s};
        addr_inc   = s.addr + 6'h01;

        next_s.sclk_q    = sclk_s;
        next_s.wr_strobe = 1'b0;
        next_s.two_wire  = cs_s;

        if (cs_s) begin
            // Deselected: end the frame, release both data pins
            next_s.bit_cnt    = 3'h0;
            next_s.in_hdr     = 1'b1;
            next_s.first_done = 1'b0;
            next_s.drive      = 1'b0;
            // Output bit keeps its value; only moved by a fall
            next_s.sdio_oe    = 1'b0;
            next_s.sdo_oe     = 1'b0;
        end else begin
            // Four-wire output pin is owned while selected
            next_s.sdo_oe = ~three_wire;
            if (rise) begin
                // Capture one bit per rising edge
                next_s.rx      = rx_next;
                next_s.bit_cnt = s.bit_cnt + 3'h1;
                if (s.bit_cnt == srsp_pkg::LAST_BIT) begin
                    if (s.in_hdr) begin
                        // Header byte: direction, flag, address
                        next_s.in_hdr          = 1'b0;
                        next_s.rw              = rx_next[srsp_pkg::HDR_RW_BIT];
                        next_s.multi_byte_flag = rx_next[srsp_pkg::HDR_MB_BIT];
                        next_s.addr            = rx_next[srsp_pkg::ADDR_W-1:0];
                        next_s.tx              = s.regs[rx_next[srsp_pkg::ADDR_W-1:0]];
                        next_s.drive           = rx_next[srsp_pkg::HDR_RW_BIT];
                    end else begin
                        // Data byte: store on write (first byte only without flag), step pointer with flag
                        if (!s.rw && (s.multi_byte_flag || !s.first_done)) begin
                            next_s.regs[s.addr] = rx_next;
                            next_s.wr_strobe    = 1'b1;
                            next_s.wr_addr      = s.addr;
                            next_s.wr_data      = rx_next;
                        end
                        next_s.first_done = 1'b1;
                        if (s.multi_byte_flag) begin
                            next_s.addr = addr_inc;
                            next_s.tx   = s.regs[addr_inc];
                        end else begin
                            next_s.tx   = s.regs[s.addr];
                        end
                    end
                end
            end else if (fall && s.drive) begin
                // Present next read bit after falling edge
                next_s.out_bit = s.tx[srsp_pkg::DATA_W-1];
                next_s.tx      = {s.tx[srsp_pkg::DATA_W-2:0], 1'b0};
                next_s.sdio_oe = three_wire;
            end
        end
    end

    // Single state register, frozen while the enable is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s                 <= '0;
            s.sclk_q          <= 1'b1;
            s.in_hdr          <= 1'b1;
            s.two_wire        <= 1'b1;
            s.regs            <= {srsp_pkg::REG_COUNT{srsp_pkg::REG_RESET}};
            s.regs[srsp_pkg::FMT_OFFSET] <= srsp_pkg::FMT_RESET;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // Outputs straight from state flip-flops
    assign sdio_out              = s.out_bit;
    assign sdio_oe               = s.sdio_oe;
    assign sdo_out               = s.out_bit;
    assign sdo_oe                = s.sdo_oe;
    assign two_wire_mode         = s.two_wire;
    assign output_format_control = s.regs[srsp_pkg::FMT_OFFSET];
    assign reg_wr_strobe         = s.wr_strobe;
    assign reg_wr_addr           = s.wr_addr;
    assign reg_wr_data           = s.wr_data;
endmodule
`default_nettype wire

// ==== testbench/srsp_checker.sv ====
// Assertions on the slave port pins and register outputs
`timescale 1ns/1ps
`default_nettype none
module srsp_checker (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       ce,
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic       sdio_in,
    input wire logic       sdio_out,
    input wire logic       sdio_oe,
    input wire logic       sdo_out,
    input wire logic       sdo_oe,
    input wire logic       two_wire_mode,
    input wire logic       reg_wr_strobe,
    input wire logic [7:0] output_format_control,
    input wire logic [7:0] reg_wr_data,
    input wire logic [5:0] reg_wr_addr
);
    // All checks on the core clock
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_mode_from_cs: assert property ($stable(cs_n) [*5] |-> two_wire_mode == cs_n)
        else $error("mode select wrong");
    a_wr_in_spi: assert property (reg_wr_strobe |-> !two_wire_mode)
        else $error("write outside SPI mode");
    a_one_driver: assert property (!(sdio_oe && sdo_oe))
        else $error("both data pins driven");
    a_three_wire_sel: assert property (sdio_oe |-> output_format_control[6])
        else $error("shared pin driven in 4-wire");
    a_four_wire_sel: assert property (output_format_control[6] && $past(output_format_control[6]) |-> !sdo_oe)
        else $error("sdo driven in 3-wire");
    a_idle_release: assert property (cs_n [*5] |-> !sdio_oe && !sdo_oe)
        else $error("pin driven while idle");
    a_out_after_fall: assert property ($changed(sdo_out) && $past(sdo_oe || sdio_oe) |-> !$past(sclk, 2))
        else $error("output moved off falling edge");
    a_wr_on_rise: assert property (reg_wr_strobe |-> $past(sclk, 2) && !$past(reg_wr_strobe))
        else $error("write strobe timing wrong");
    a_fmt_write: assert property (reg_wr_strobe && reg_wr_addr == 6'h31 |-> output_format_control == reg_wr_data)
        else $error("format register not written");
    a_fmt_hold: assert property (!reg_wr_strobe |-> $stable(output_format_control))
        else $error("format register changed");
endmodule
bind srsp_port srsp_checker u_chk (.clk, .resetn, .ce, .cs_n, .sclk, .sdio_in, .sdio_out, .sdio_oe, .sdo_out,
    .sdo_oe, .two_wire_mode, .reg_wr_strobe, .output_format_control, .reg_wr_data, .reg_wr_addr);
`default_nettype wire

// ==== testbench/srsp_host_model.sv ====
// Bus master model: mode 3 frames at 80 ns serial clock
`timescale 1ns/1ps
`default_nettype none
module srsp_host_model (
    input  wire logic clk, sdio_out, sdio_oe, sdo_out, sdo_oe,
    output logic      cs_n, sclk, sdi
);
    logic drv = 1'b1;
    logic md = 1'b0;
    initial cs_n = 1'b1;
    initial sclk = 1'b1;
    // Wire level: clash gives x, released master pin toggles
    assign sdi = sdio_oe ? (drv ? 1'bx : sdio_out) : md;
    // Half of the 80 ns serial period
    task automatic half;
        repeat (8) @(posedge clk);
    endtask
    task automatic xfer(input logic [7:0] tx[$], input int nrd, input logic tw, output logic [7:0] rx[$]);
        logic [7:0] b;
        rx = {};
        half();
        cs_n <= 1'b0;
        for (int i = 0; i < tx.size() + nrd; i++) begin
            for (int k = 7; k >= 0; k--) begin
                half();
                sclk <= 1'b0;
                drv <= i < tx.size();
                md <= (i < tx.size()) ? tx[i][k] : ~md;
                half();
                sclk <= 1'b1;
                b[k] = tw ? sdi : (sdo_oe ? sdo_out : 1'bx);
            end
            if (i >= tx.size()) rx.push_back(b);
        end
        half();
        cs_n <= 1'b1;
        drv <= 1'b1;
        half();
    endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Register traffic through the serial slave port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       cs_n, sclk, sdi, sdio_out, sdio_oe, sdo_out, sdo_oe, two_wire_mode, reg_wr_strobe;
    logic [7:0] output_format_control, reg_wr_data;
    logic [5:0] reg_wr_addr;
    logic [7:0] rx[$];
    int         fail_count = 0;
    int         n_checks = 0;
    srsp_port u_srsp_port (.clk, .resetn, .ce(1'b1), .cs_n, .sclk, .sdio_in(sdi), .sdio_out, .sdio_oe, .sdo_out,
        .sdo_oe, .two_wire_mode, .output_format_control, .reg_wr_strobe, .reg_wr_addr, .reg_wr_data);
    srsp_host_model host (.clk, .cs_n, .sclk, .sdi, .sdio_out, .sdio_oe, .sdo_out, .sdo_oe);
    initial forever #2.5 clk = ~clk;
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Read frame, then compare each returned byte
    task automatic rd(input logic [7:0] hdr, input int n, input logic tw, input logic [7:0] e[$]);
        host.xfer({hdr}, n, tw, rx);
        foreach (e[i]) chk("read byte", e[i], rx[i]);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic do_reset;
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    initial begin
        do_reset();
        chk("two_wire_mode", 8'h01, two_wire_mode);
        chk("format", 8'h00, output_format_control);
        host.xfer({8'h7e, 8'ha1, 8'hb2, 8'hc3}, 0, 1'b0, rx);
        chk("wr_addr", 8'h00, reg_wr_addr);
        chk("wr_data", 8'hc3, reg_wr_data);
        rd(8'hfe, 3, 1'b0, {8'ha1, 8'hb2, 8'hc3});
        host.xfer({8'h05, 8'h55, 8'h66}, 0, 1'b0, rx);
        rd(8'h85, 2, 1'b0, {8'h55, 8'h55});
        host.xfer({8'h31, 8'h40}, 0, 1'b0, rx);
        chk("format", 8'h40, output_format_control);
        rd(8'hfe, 2, 1'b1, {8'ha1, 8'hb2});
        do_reset();
        chk("format", 8'h00, output_format_control);
        rd(8'hfe, 1, 1'b0, {8'h00});
        close_out();
    end
    // Watchdog
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
endmodule
`default_nettype wire
